// ==== rtl/fbeod_dictionary.sv ====
`timescale 1ns/100ps
// Behaviour
// - A read-only 32-bit device type word holds the profile in its low half and options above.
// - The read-only error summary byte has bit 0 set whenever any fault is active, counting feedback faults only with encoder feedback.
// - History subindex 0 reads the number of recorded errors.
// - Subindexes 1..FF hold recorded codes, newest always at subindex 1.
// - Only faults announced by an emergency message enter the history.
// - Writing zero to history subindex 0 clears the whole history.
// - DC bus faults use codes 3210, 3220 and 3221.
// - Thermal faults use 4210 or 4280, 4310 and 4410.
// - An option unit fault is 5481 and an object content selection failure is 6301.
// - External faults on inputs 3 to 7 are 5441..5445, on inputs 1 and 2 FF0D and FF0E.
// - Control supply undervoltage is 5200, panel loss 5300, memory error 5530.
// - With encoder feedback, overspeed is 7180, feedback loss 7305, deviation 8321.
// - Vendor alarms use FF-prefixed codes such as FF3B, FF07 and FF08.
// - A 32-bit read/write entry sets the SYNC identifier and whether this node produces it.
// - Device name and hardware version are read-only strings that may not be mapped.
module fbeod_dictionary #(
    parameter int DEPTH = fbeod_pkg::HISTORY_DEPTH,
    parameter int N     = fbeod_pkg::FAULT_COUNT
) (
    input  wire logic                 clock_in,
    input  wire logic                 arst_n_in,
    input  wire fbeod_pkg::fbeod_req_t req_in,
    output fbeod_pkg::fbeod_rsp_t     rsp_out,
    input  wire logic [N-1:0]         fault_active_in,
    input  wire logic [N-1:0]         fault_announced_in,
    input  wire logic                 encoder_vf_mode_in,
    output logic                      fault_taken_out,
    output logic [31:0]               sync_identifier_out,
    output logic                      sync_producer_out,
    output logic [7:0]                error_count_out
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [7:0]          count;
        logic [31:0]         sync_id;
        fbeod_pkg::fbeod_rsp_t rsp;
        logic [N-1:0]        logged;
    } fbeod_state_t;

    fbeod_state_t state;
    fbeod_state_t next_state;

    // History storage lives outside the struct: a 255-word array
    logic [15:0] history [DEPTH];

    logic [N-1:0] gate_mask;
    logic [N-1:0] new_fault;
    logic         found;
    logic [15:0]  new_code;
    logic [N-1:0] taken;
    logic         any_fault;
    logic         clear_req;
    logic [7:0]   sub;

    // ==========================================================
    // Fault capture
    always_comb begin
        gate_mask = '1;
        if (!encoder_vf_mode_in) begin
            for (int i = fbeod_pkg::PG_FIRST; i <= fbeod_pkg::PG_LAST; i++) begin
                gate_mask[i] = 1'b0;
            end
        end
    end

    // A fault is logged once per rising: it must be active, announced, not yet logged
    assign new_fault = fault_active_in & fault_announced_in & gate_mask & ~state.logged;
    assign any_fault = |(fault_active_in & gate_mask);

    fbeod_fault_encoder #(
        .N (N)
    ) u_encoder (
        .new_fault_in (new_fault),
        .found_out    (found),
        .code_out     (new_code),
        .taken_out    (taken)
    );

    assign sub       = req_in.subindex;
    assign clear_req = req_in.valid && req_in.write && req_in.index == fbeod_pkg::IDX_ERROR_HISTORY
                       && sub == 8'h00 && req_in.wdata == 32'h0000_0000
                       && !req_in.pdo_map;  // A refused mapping request must not clear

    // ==========================================================
    // Next state and answers
    always_comb begin
        next_state = state;
        next_state.rsp.valid  = 1'b0;
        next_state.rsp.status = fbeod_pkg::FBEOD_ACK_OK;
        next_state.rsp.rdata  = 32'h0000_0000;
        // Clear the logged mark when a fault goes away so a repeat logs again
        next_state.logged = (state.logged & fault_active_in) | taken;

        if (clear_req) begin
            next_state.count = 8'h00;
        end else if (found && state.count != fbeod_pkg::HISTORY_LAST_SUB) begin
            next_state.count = state.count + 8'h01;
        end

        if (req_in.valid) begin
            next_state.rsp.valid = 1'b1;
            if (req_in.pdo_map && req_in.index != fbeod_pkg::IDX_FAULT_SUMMARY) begin
                next_state.rsp.status = fbeod_pkg::FBEOD_ACK_RANGE;
            end else begin
                case (req_in.index)
                    fbeod_pkg::IDX_DEVICE_PROFILE: begin
                        if (req_in.write) begin
                            next_state.rsp.status = fbeod_pkg::FBEOD_ACK_RDONLY;
                        end else begin
                            next_state.rsp.rdata = {fbeod_pkg::PROFILE_OPTIONS,
                                                    fbeod_pkg::PROFILE_NUMBER};
                        end
                    end
                    fbeod_pkg::IDX_FAULT_SUMMARY: begin
                        if (req_in.write) begin
                            next_state.rsp.status = fbeod_pkg::FBEOD_ACK_RDONLY;
                        end else begin
                            next_state.rsp.rdata[fbeod_pkg::GENERIC_ERROR_BIT] = any_fault;
                        end
                    end
                    fbeod_pkg::IDX_ERROR_HISTORY: begin
                        if (sub == 8'h00) begin
                            if (req_in.write && req_in.wdata != 32'h0000_0000) begin
                                // Only zero is a legal write to the count
                                next_state.rsp.status = fbeod_pkg::FBEOD_ACK_RANGE;
                            end else if (!req_in.write) begin
                                next_state.rsp.rdata = {24'h000000, state.count};
                            end
                        end else if (req_in.write) begin
                            next_state.rsp.status = fbeod_pkg::FBEOD_ACK_RDONLY;
                        end else if (sub > state.count) begin
                            next_state.rsp.status = fbeod_pkg::FBEOD_ACK_NOOBJ;
                        end else begin
                            next_state.rsp.rdata = {16'h0000, history[sub - 8'h01]};
                        end
                    end
                    fbeod_pkg::IDX_SYNC_IDENTIFIER: begin
                        if (req_in.write) begin
                            next_state.sync_id = req_in.wdata;
                        end else begin
                            next_state.rsp.rdata = state.sync_id;
                        end
                    end
                    fbeod_pkg::IDX_DEVICE_NAME: begin
                        if (req_in.write) begin
                            next_state.rsp.status = fbeod_pkg::FBEOD_ACK_RDONLY;
                        end else begin
                            next_state.rsp.rdata = fbeod_pkg::DEVICE_NAME_TEXT;
                        end
                    end
                    fbeod_pkg::IDX_HW_VERSION: begin
                        if (req_in.write) begin
                            next_state.rsp.status = fbeod_pkg::FBEOD_ACK_RDONLY;
                        end else begin
                            next_state.rsp.rdata = fbeod_pkg::HW_VERSION_TEXT;
                        end
                    end
                    default: begin
                        next_state.rsp.status = fbeod_pkg::FBEOD_ACK_NOOBJ;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state.count   <= 8'h00;
            state.sync_id <= fbeod_pkg::SYNC_ID_RESET;
            state.rsp     <= '0;
            state.logged  <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Shift register, no reset: stale words are hidden by the count
    always_ff @(posedge clock_in) begin
        if (found && !clear_req) begin
            history[0] <= new_code;
            for (int i = 1; i < DEPTH; i++) begin
                history[i] <= history[i - 1];
            end
        end
    end

    // ==========================================================
    // Outputs
    assign rsp_out             = state.rsp;
    assign fault_taken_out     = found;
    assign sync_identifier_out = state.sync_id;
    assign sync_producer_out   = state.sync_id[30];
    assign error_count_out     = state.count;

endmodule // fbeod_dictionary

// ==== rtl/fbeod_fault_encoder.sv ====
`timescale 1ns/100ps
// Picks the lowest numbered newly raised fault and its code
module fbeod_fault_encoder #(
    parameter int N = fbeod_pkg::FAULT_COUNT
) (
    input  wire logic [N-1:0] new_fault_in,
    output logic              found_out,
    output logic [15:0]       code_out,
    output logic [N-1:0]      taken_out
);
    always_comb begin
        found_out = 1'b0;
        code_out  = 16'h0000;
        taken_out = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (new_fault_in[i]) begin
                found_out = 1'b1;
                code_out  = fbeod_pkg::FAULT_CODES[i];
                taken_out = '0;
                taken_out[i] = 1'b1;
            end
        end
    end
endmodule // fbeod_fault_encoder

// ==== rtl/fbeod_pkg.sv ====
package fbeod_pkg;

    // ==========================================================
    // Dictionary indexes
    localparam logic [15:0] IDX_DEVICE_PROFILE   = 16'h1000;
    localparam logic [15:0] IDX_FAULT_SUMMARY    = 16'h1001;
    localparam logic [15:0] IDX_ERROR_HISTORY    = 16'h1003;
    localparam logic [15:0] IDX_SYNC_IDENTIFIER  = 16'h1005;
    localparam logic [15:0] IDX_DEVICE_NAME      = 16'h1008;
    localparam logic [15:0] IDX_HW_VERSION       = 16'h1009;

    // ==========================================================
    // Field positions and reset values
    localparam int          GENERIC_ERROR_BIT    = 0;
    localparam int          HISTORY_DEPTH        = 255;
    localparam logic [7:0]  HISTORY_LAST_SUB     = 8'hFF;
    localparam logic [31:0] SYNC_ID_RESET        = 32'h0000_0080;
    localparam logic [15:0] PROFILE_NUMBER       = 16'h0192;
    localparam logic [15:0] PROFILE_OPTIONS      = 16'h0000;
    // Arbitrary neutral identification strings
    localparam logic [31:0] DEVICE_NAME_TEXT     = 32'h4452_5631;
    localparam logic [31:0] HW_VERSION_TEXT      = 32'h4857_3031;

    // ==========================================================
    // Fault sources and their history codes
    localparam int          FAULT_COUNT          = 26;
    localparam logic [15:0] FAULT_CODES [FAULT_COUNT] = '{
        16'h3210, 16'h3220, 16'h3221, 16'h4210, 16'h4280, 16'h4310,
        16'h4410, 16'h5481, 16'h6301, 16'h5441, 16'h5442, 16'h5443,
        16'h5444, 16'h5445, 16'hFF0D, 16'hFF0E, 16'h5200, 16'h5300,
        16'h5530, 16'h7180, 16'h7305, 16'h8321, 16'hFF3B, 16'hFF07,
        16'hFF08, 16'hFF01
    };
    localparam int          PG_FIRST             = 19;
    localparam int          PG_LAST              = 21;

    // ==========================================================
    // Access request / answer
    typedef enum logic [1:0] {
        FBEOD_ACK_OK     = 2'b00,
        FBEOD_ACK_NOOBJ  = 2'b01,
        FBEOD_ACK_RDONLY = 2'b10,
        FBEOD_ACK_RANGE  = 2'b11
    } fbeod_ack_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] index;
        logic [7:0]  subindex;
        logic [31:0] wdata;
        logic        pdo_map;
    } fbeod_req_t;

    typedef struct packed {
        logic        valid;
        fbeod_ack_t  status;
        logic [31:0] rdata;
    } fbeod_rsp_t;

endpackage

// ==== test/fbeod_checker.sv ====
`timescale 1ns/100ps
module fbeod_checker #(
    parameter int N = 26
) (
    input wire logic                  clock_in,
    input wire logic                  arst_n_in,
    input wire fbeod_pkg::fbeod_req_t req_in,
    input wire fbeod_pkg::fbeod_rsp_t rsp_out,
    input wire logic [N-1:0]          fault_active_in,
    input wire logic [N-1:0]          fault_announced_in,
    input wire logic                  encoder_vf_mode_in,
    input wire logic                  fault_taken_out,
    input wire logic [31:0]           sync_identifier_out,
    input wire logic                  sync_producer_out,
    input wire logic [7:0]            error_count_out
);
    // ==========================================================
    // Properties
    wire logic rq  = req_in.valid && !req_in.pdo_map;
    wire logic rd  = rq && !req_in.write && req_in.subindex == 8'h00;
    wire logic wr  = rq && req_in.write;
    wire logic clr = wr && req_in.index == 16'h1003 && req_in.subindex == 8'h00
                     && req_in.wdata == 32'h0;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    chk_rsp_one_later: assert property (req_in.valid |=> rsp_out.valid)
        else $error("no answer one cycle after request");
    chk_rsp_no_extra: assert property (!req_in.valid |=> !rsp_out.valid)
        else $error("answer without request");
    chk_profile_word: assert property (rd && req_in.index == 16'h1000 |=>
        rsp_out.status == 2'h0 && rsp_out.rdata[15:0] == fbeod_pkg::PROFILE_NUMBER)
        else $error("device type read wrong");
    chk_ro_refused: assert property (wr && req_in.index inside
        {16'h1000, 16'h1001, 16'h1008, 16'h1009} |=> rsp_out.status == 2'h2)
        else $error("read-only write not refused");
    chk_pdo_refused: assert property (req_in.valid && req_in.pdo_map &&
        req_in.index inside {16'h1000, 16'h1008, 16'h1009} |=> rsp_out.status == 2'h3)
        else $error("mapping not refused");
    chk_summary_bit: assert property (rd && req_in.index == 16'h1001
        && encoder_vf_mode_in ##1 $stable(fault_active_in) |-> rsp_out.rdata[0] == |fault_active_in)
        else $error("generic error bit wrong");
    chk_count_step: assert property (fault_taken_out && !clr
        && error_count_out != 8'hFF |=> error_count_out == $past(error_count_out) + 8'h01)
        else $error("count did not step");
    chk_count_hold: assert property (!fault_taken_out && !clr
        |=> $stable(error_count_out))
        else $error("count moved");
    chk_count_full: assert property (fault_taken_out && error_count_out == 8'hFF
        |=> error_count_out == 8'hFF)
        else $error("full count moved");
    chk_history_clear: assert property (clr |=> error_count_out == 8'h00)
        else $error("history not cleared");
    chk_taken_announced: assert property (fault_taken_out |->
        |(fault_active_in & fault_announced_in))
        else $error("unannounced fault logged");
    chk_sync_write: assert property (wr && req_in.index == 16'h1005 |=>
        sync_identifier_out == $past(req_in.wdata) && sync_producer_out == $past(req_in.wdata[30]))
        else $error("sync entry not written");
    cover property (fault_taken_out);
    cover property (error_count_out == 8'hFF);
    cover property (clr);
    cover property (wr && req_in.index == 16'h1005);
endmodule // fbeod_checker

// ==== test/fbeod_dictionary_tb.sv ====
`timescale 1ns/100ps
module fbeod_dictionary_tb;
    // ==========================================================
    // Harness
    typedef struct packed {logic [1:0] st; logic [31:0] rd; logic [31:0] mk;} fbeod_exp_t;
    localparam logic [15:0] H = 16'h1003;
    localparam logic [15:0] CODE [26] = '{16'h3210, 16'h3220, 16'h3221, 16'h4210, 16'h4280,
        16'h4310, 16'h4410, 16'h5481, 16'h6301, 16'h5441, 16'h5442, 16'h5443, 16'h5444,
        16'h5445, 16'hFF0D, 16'hFF0E, 16'h5200, 16'h5300, 16'h5530, 16'h7180, 16'h7305,
        16'h8321, 16'hFF3B, 16'hFF07, 16'hFF08, 16'hFF01};
    localparam logic [15:0] RO [4] = '{16'h1000, 16'h1001, 16'h1008, 16'h1009};
    logic                  clock_in = 1'h0;
    logic                  arst_n_in = 1'h0;
    logic                  enc = 1'h1;
    logic [25:0]           act = '0;
    logic [25:0]           ann = '0;
    fbeod_pkg::fbeod_req_t req;
    fbeod_pkg::fbeod_rsp_t rsp;
    logic [31:0]           sid;
    logic [31:0]           sv;
    logic                  sprod;
    logic [7:0]            cnt;
    int                    n_fail = 0;
    int                    samples_checked = 0;
    fbeod_exp_t            q[$];
    fbeod_exp_t            e;
    always #5 clock_in = ~clock_in;
    fbeod_master_model m (.clock_in(clock_in), .req_out(req));
    fbeod_dictionary dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .req_in(req),
        .rsp_out(rsp), .fault_active_in(act), .fault_announced_in(ann),
        .encoder_vf_mode_in(enc), .fault_taken_out(), .sync_identifier_out(sid),
        .sync_producer_out(sprod), .error_count_out(cnt));
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb,
        input logic [31:0] wd, input logic pm, input logic [1:0] st, input logic [31:0] rd,
        input logic [31:0] mk);
        q.push_back('{st, rd, mk});
        m.send(w, ix, sb, wd, pm);
    endtask
    task automatic hit(input int i, input logic an);
        @(negedge clock_in);
        act[i] = 1'h1;
        ann[i] = an;
        repeat (3) @(negedge clock_in);
        act[i] = 1'h0;
        ann[i] = 1'h0;
    endtask
    task automatic done(input string name);
        repeat (20) if (q.size() != 0) @(negedge clock_in);
        if (q.size() != 0) begin
            n_fail++;
            wrap_up();
        end
        $display("test %s done", name);
    endtask
    always @(negedge clock_in) if (rsp.valid === 1'h1) begin
        e = q.pop_front();
        chk({rsp.status, rsp.rdata & e.mk}, {e.st, e.rd});
    end
    initial begin
        #500000;
        n_fail++;
        wrap_up();
    end
    // ==========================================================
    // Scenarios
    initial begin
        void'($urandom(32'hBA3A));
        repeat (3) @(negedge clock_in);
        arst_n_in = 1'h1;
        acc(1'h0, RO[0], 8'h00, 32'h0, 1'h0, 2'h0, 32'h192, 32'hFFFF);
        foreach (RO[i]) acc(1'h1, RO[i], 8'h00, $urandom, 1'h0, 2'h2, 32'h0, 32'h0);
        acc(1'h0, RO[2], 8'h00, 32'h0, 1'h1, 2'h3, 32'h0, 32'h0);
        acc(1'h0, RO[1], 8'h00, 32'h0, 1'h1, 2'h0, 32'h0, 32'h0);
        acc(1'h0, 16'h1234, 8'h00, 32'h0, 1'h0, 2'h1, 32'h0, 32'h0);
        sv = {1'h0, 1'($urandom), 19'h0, 11'($urandom)};
        acc(1'h1, 16'h1005, 8'h00, sv, 1'h0, 2'h0, 32'h0, 32'h0);
        acc(1'h0, 16'h1005, 8'h00, 32'h0, 1'h0, 2'h0, sv, '1);
        done("entries");
        chk({1'h0, sprod, sid}, {1'h0, sv[30], sv});
        acc(1'h1, H, 8'h00, 32'h5, 1'h0, 2'h3, 32'h0, 32'h0);
        for (int i = 0; i < 26; i++) hit(i, 1'h1);
        hit(0, 1'h0);
        enc = 1'h0;
        hit(19, 1'h1);
        enc = 1'h1;
        act[3] = 1'h1;
        acc(1'h0, RO[1], 8'h00, 32'h0, 1'h0, 2'h0, 32'h1, 32'h1);
        done("summary");
        act[3] = 1'h0;
        acc(1'h0, RO[1], 8'h00, 32'h0, 1'h0, 2'h0, 32'h0, 32'h1);
        acc(1'h0, H, 8'h00, 32'h0, 1'h0, 2'h0, 32'd26, 32'hFF);
        for (int k = 1; k <= 26; k++) begin
            acc(1'h0, H, 8'(k), 32'h0, 1'h0, 2'h0, CODE[26-k], '1);
        end
        acc(1'h0, H, 8'h1B, 32'h0, 1'h0, 2'h1, 32'h0, 32'h0);
        acc(1'h1, H, 8'h00, 32'h0, 1'h1, 2'h3, 32'h0, 32'h0);
        acc(1'h0, H, 8'h00, 32'h0, 1'h0, 2'h0, 32'd26, 32'hFF);
        acc(1'h1, H, 8'h00, 32'h0, 1'h0, 2'h0, 32'h0, 32'h0);
        acc(1'h0, H, 8'h00, 32'h0, 1'h0, 2'h0, 32'h0, 32'hFF);
        acc(1'h0, H, 8'h01, 32'h0, 1'h0, 2'h1, 32'h0, 32'h0);
        done("history");
        chk({26'h0, cnt}, 34'h0);
        for (int k = 0; k < 256; k++) hit(k % 3, 1'h1);
        acc(1'h0, H, 8'h00, 32'h0, 1'h0, 2'h0, 32'hFF, 32'hFF);
        acc(1'h0, H, 8'h01, 32'h0, 1'h0, 2'h0, CODE[0], '1);
        acc(1'h0, H, 8'hFF, 32'h0, 1'h0, 2'h0, CODE[1], '1);
        done("rollover");
        chk({26'h0, cnt}, {26'h0, 8'hFF});
        wrap_up();
    end
endmodule // fbeod_dictionary_tb

bind fbeod_dictionary fbeod_checker #(.N(N)) u_chk (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .req_in(req_in), .rsp_out(rsp_out),
    .fault_active_in(fault_active_in), .fault_announced_in(fault_announced_in),
    .encoder_vf_mode_in(encoder_vf_mode_in),
    .fault_taken_out(fault_taken_out), .sync_identifier_out(sync_identifier_out),
    .sync_producer_out(sync_producer_out), .error_count_out(error_count_out));

// ==== test/fbeod_master_model.sv ====
`timescale 1ns/100ps
module fbeod_master_model (
    input  wire logic             clock_in,
    output fbeod_pkg::fbeod_req_t req_out
);
    // ==========================================================
    // One access at a time; a gap cycle avoids a double drive of valid
    initial req_out = '0;
    task automatic send(input logic w, input logic [15:0] ix, input logic [7:0] sb,
                        input logic [31:0] wd, input logic pm);
        @(negedge clock_in);
        req_out <= '{1'h1, w, ix, sb, wd, pm};
        @(negedge clock_in);
        req_out.valid <= 1'h0;
    endtask
endmodule // fbeod_master_model
